// ---- logic/crb_timer.sv ----
// 16-bit capture / auto-reload / baud-rate timer with an AXI4-Lite slave.
// Assumes pins are synchronous to aclk and timer1_overflow is a one-cycle pulse.
//
// Functional notes
// R01 Overflow sets overflow flag; only software clears.
// R02 No overflow flag while any baud select set.
// R03 Enabled trigger capture/reload sets external event flag.
// R04 Either flag requests the one timer interrupt.
// R05 Rx select one: port one receive clock source.
// R06 Tx select one: port one transmit clock source.
// R07 Trigger enable gates trigger events, not baud.
// R08 Run bit clear stops counting in all modes.
// R09 Counter select: machine cycles or count pin.
// R10 Capture select: capture on trigger, else reload.
// R11 Baud mode always reloads on overflow.
// R12 Capture mode counts upward, overflow flag on rollover.
// R13 Baud mode trigger only sets external event flag.
// R14 Second select pair clocks serial port two.
// R15 Direction enable: trigger low down, high up.
// R16 Capture copies count into capture/reload register.
// R17 Reload loads count from capture/reload register.
`timescale 1ns/1ns
`default_nettype none
module crb_timer #(
  parameter int MC_DIV = crb_pkg::MC_DIV
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        count_input_pin,
  input  wire logic        trigger_input_pin,
  input  wire logic        timer1_overflow,
  output logic             rx_clock_one,
  output logic             tx_clock_one,
  output logic             rx_clock_two,
  output logic             tx_clock_two,
  output logic             irq
);

  localparam int MCW = $clog2(MC_DIV);

  if (MC_DIV < 2) begin : g_chk
    $error("crb_timer needs MC_DIV of at least 2");
  end

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == crb_pkg::OFF_CONTROL) || (a == crb_pkg::OFF_MODE_EXT) ||
                (a == crb_pkg::OFF_POWER_CTRL) || (a == crb_pkg::OFF_COUNT) ||
                (a == crb_pkg::OFF_CAP_RELOAD) || (a == crb_pkg::OFF_IRQ_STATUS) ||
                (a == crb_pkg::OFF_IRQ_MASK);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = old;
    for (int b = 0; b < 2; b++) begin
      if (s[b]) begin
        merge16[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction

  // ==========================================================================
  // AXI4-Lite handshake
  logic        aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0]  wr_addr, next_wr_addr;
  logic [31:0] wr_data, next_wr_data;
  logic [3:0]  wr_strb, next_wr_strb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_word;
  logic        wr_go;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  // Address and data may arrive in either order; the write lands once both are held.
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp  = is_mapped(wr_addr) ? crb_pkg::RESP_OKAY : crb_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid  = 1'b0;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = is_mapped(s_axi_araddr) ? crb_pkg::RESP_OKAY : crb_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= 8'h00;
      wr_data      <= 32'h0000_0000;
      wr_strb      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= crb_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= crb_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      wr_addr      <= next_wr_addr;
      wr_data      <= next_wr_data;
      wr_strb      <= next_wr_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
    end
  end

  // ==========================================================================
  // Registers and counter
  logic [7:0]     control, next_control;
  logic           direction_enable, next_direction_enable;
  logic [1:0]     power_sel, next_power_sel;
  logic [15:0]    count, next_count;
  logic [15:0]    cap_reload, next_cap_reload;
  logic [1:0]     irq_mask, next_irq_mask;
  logic [MCW-1:0] mc_cnt, next_mc_cnt;
  logic [1:0]     pin_fall;
  logic           mc_tick, tick, baud, dir_down, trig_ev, up_ovf, dn_ovf, ovf;
  logic           ctl_wr, cnt_wr, cap_wr, stat_wr;
  crb_pkg::crb_mode_t mode;

  crb_fall_detect #(
    .WIDTH (2)
  ) u_fall (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   ({trigger_input_pin, count_input_pin}),
    .fall    (pin_fall)
  );

  assign mc_tick  = (mc_cnt == MCW'(MC_DIV - 1));
  assign tick     = control[crb_pkg::BIT_RUN] &&                                       // R08
                    (control[crb_pkg::BIT_CNT_SEL] ? pin_fall[0] : mc_tick);           // R09
  assign baud     = control[crb_pkg::BIT_RX1] || control[crb_pkg::BIT_TX1] ||
                    power_sel[crb_pkg::BIT_RX2] || power_sel[crb_pkg::BIT_TX2];        // R14
  assign mode     = baud ? crb_pkg::CRB_MODE_BAUD :                                    // R11
                    (control[crb_pkg::BIT_CPRL] ? crb_pkg::CRB_MODE_CAPTURE : crb_pkg::CRB_MODE_RELOAD);
  assign dir_down = (mode == crb_pkg::CRB_MODE_RELOAD) && direction_enable && !trigger_input_pin; // R15
  // With direction enabled in reload mode the trigger pin is a level, so its edges are not events.
  assign trig_ev  = pin_fall[1] && control[crb_pkg::BIT_TRIG_EN] &&                    // R07
                    !((mode == crb_pkg::CRB_MODE_RELOAD) && direction_enable);
  assign up_ovf   = tick && !dir_down && (count == crb_pkg::COUNT_MAX);
  assign dn_ovf   = tick && dir_down && (count == cap_reload);
  assign ovf      = up_ovf || dn_ovf;
  assign ctl_wr   = wr_go && (wr_addr == crb_pkg::OFF_CONTROL) && wr_strb[0];
  assign cnt_wr   = wr_go && (wr_addr == crb_pkg::OFF_COUNT) && (|wr_strb[1:0]);
  assign cap_wr   = wr_go && (wr_addr == crb_pkg::OFF_CAP_RELOAD) && (|wr_strb[1:0]);
  assign stat_wr  = wr_go && (wr_addr == crb_pkg::OFF_IRQ_STATUS) && wr_strb[0];

  always_comb begin
    next_control          = control;
    next_direction_enable = direction_enable;
    next_power_sel        = power_sel;
    next_count            = count;
    next_cap_reload       = cap_reload;
    next_irq_mask         = irq_mask;
    next_mc_cnt           = mc_tick ? '0 : MCW'(mc_cnt + 1'b1);
    // Counting first; a software write to the same register below takes precedence.
    case (mode)
      crb_pkg::CRB_MODE_CAPTURE: begin
        if (tick) begin
          next_count = count + 16'h0001;                                               // R12
        end
        if (trig_ev) begin
          next_cap_reload = count;                                                     // R16
        end
      end
      crb_pkg::CRB_MODE_RELOAD, crb_pkg::CRB_MODE_BAUD: begin
        if (dn_ovf) begin
          next_count = crb_pkg::COUNT_MAX;                                             // R15
        end else if (up_ovf) begin
          next_count = cap_reload;                                                     // R17
        end else if (tick) begin
          next_count = dir_down ? count - 16'h0001 : count + 16'h0001;
        end
        if (trig_ev && (mode == crb_pkg::CRB_MODE_RELOAD)) begin
          next_count = cap_reload;                                                     // R10
        end
      end
      default: begin
        next_count = count;
      end
    endcase
    if (ctl_wr) begin
      next_control = wr_data[7:0];
    end
    if (stat_wr) begin
      next_control[crb_pkg::BIT_OVF] = control[crb_pkg::BIT_OVF] & ~wr_data[crb_pkg::IRQ_OVF];
      next_control[crb_pkg::BIT_EXT] = control[crb_pkg::BIT_EXT] & ~wr_data[crb_pkg::IRQ_EXT];
    end
    if (wr_go && (wr_addr == crb_pkg::OFF_MODE_EXT) && wr_strb[0]) begin
      next_direction_enable = wr_data[crb_pkg::BIT_DIR_EN];
    end
    if (wr_go && (wr_addr == crb_pkg::OFF_POWER_CTRL) && wr_strb[0]) begin
      next_power_sel = wr_data[1:0];
    end
    if (wr_go && (wr_addr == crb_pkg::OFF_IRQ_MASK) && wr_strb[0]) begin
      next_irq_mask = wr_data[1:0];
    end
    if (cnt_wr) begin
      next_count = merge16(count, wr_data, wr_strb);
    end
    if (cap_wr) begin
      next_cap_reload = merge16(cap_reload, wr_data, wr_strb);
    end
    // Hardware sets win over any software clear in the same cycle.
    if (ovf && (mode != crb_pkg::CRB_MODE_BAUD)) begin                                 // R02
      next_control[crb_pkg::BIT_OVF] = 1'b1;                                           // R01
    end
    if (trig_ev) begin
      next_control[crb_pkg::BIT_EXT] = 1'b1;                                           // R03 R13
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control          <= crb_pkg::CONTROL_RESET;
      direction_enable <= 1'b0;
      power_sel        <= 2'h0;
      count            <= crb_pkg::COUNT_RESET;
      cap_reload       <= crb_pkg::COUNT_RESET;
      irq_mask         <= crb_pkg::IRQ_RESET;
      mc_cnt           <= '0;
    end else begin
      control          <= next_control;
      direction_enable <= next_direction_enable;
      power_sel        <= next_power_sel;
      count            <= next_count;
      cap_reload       <= next_cap_reload;
      irq_mask         <= next_irq_mask;
      mc_cnt           <= next_mc_cnt;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      crb_pkg::OFF_CONTROL:    rd_word[7:0]  = control;
      crb_pkg::OFF_MODE_EXT:   rd_word[0]    = direction_enable;
      crb_pkg::OFF_POWER_CTRL: rd_word[1:0]  = power_sel;
      crb_pkg::OFF_COUNT:      rd_word[15:0] = count;
      crb_pkg::OFF_CAP_RELOAD: rd_word[15:0] = cap_reload;
      crb_pkg::OFF_IRQ_STATUS: rd_word[1:0]  = {control[crb_pkg::BIT_EXT], control[crb_pkg::BIT_OVF]};
      crb_pkg::OFF_IRQ_MASK:   rd_word[1:0]  = irq_mask;
      default:                 rd_word       = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Serial clock selection and interrupt
  logic next_rx1, next_tx1, next_rx2, next_tx2;

  always_comb begin
    next_rx1 = control[crb_pkg::BIT_RX1] ? ovf : timer1_overflow;                      // R05
    next_tx1 = control[crb_pkg::BIT_TX1] ? ovf : timer1_overflow;                      // R06
    next_rx2 = power_sel[crb_pkg::BIT_RX2] ? ovf : timer1_overflow;                    // R14
    next_tx2 = power_sel[crb_pkg::BIT_TX2] ? ovf : timer1_overflow;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_clock_one <= 1'b0;
      tx_clock_one <= 1'b0;
      rx_clock_two <= 1'b0;
      tx_clock_two <= 1'b0;
    end else begin
      rx_clock_one <= next_rx1;
      tx_clock_one <= next_tx1;
      rx_clock_two <= next_rx2;
      tx_clock_two <= next_tx2;
    end
  end

  // Both flags share one request line; the mask stands in for the interrupt enable.
  assign irq = (control[crb_pkg::BIT_OVF] && irq_mask[crb_pkg::IRQ_OVF]) ||            // R04
               (control[crb_pkg::BIT_EXT] && irq_mask[crb_pkg::IRQ_EXT]);

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ovf_flag;
    up_ovf && (mode != crb_pkg::CRB_MODE_BAUD) |=> control[crb_pkg::BIT_OVF] ##1 1'b1;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not set flag"); // R01

  property p_baud_no_flag;
    baud && !control[crb_pkg::BIT_OVF] && !ctl_wr |=> !control[crb_pkg::BIT_OVF];
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag) else $error("flag set in baud mode"); // R02

  property p_ext_flag;
    pin_fall[1] && control[crb_pkg::BIT_TRIG_EN] && !direction_enable |=> control[crb_pkg::BIT_EXT];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("trigger did not set flag"); // R03

  property p_irq;
    control[crb_pkg::BIT_EXT] && irq_mask[crb_pkg::IRQ_EXT] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("external flag gave no interrupt"); // R04

  property p_rx1;
    control[crb_pkg::BIT_RX1] && ovf |=> rx_clock_one;
  endproperty
  a_rx1: assert property (p_rx1) else $error("receive clock missed overflow"); // R05

  property p_tx1;
    !control[crb_pkg::BIT_TX1] && timer1_overflow |=> tx_clock_one;
  endproperty
  a_tx1: assert property (p_tx1) else $error("transmit clock missed timer one"); // R06

  property p_trig_off;
    !control[crb_pkg::BIT_TRIG_EN] && !cap_wr |=> $stable(cap_reload);
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("capture without trigger enable"); // R07

  property p_stop;
    !control[crb_pkg::BIT_RUN] && !cnt_wr && !trig_ev |=> $stable(count);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped"); // R08

  property p_up;
    (mode == crb_pkg::CRB_MODE_CAPTURE) && tick && !cnt_wr |=> count == 16'($past(count) + 16'h0001);
  endproperty
  a_up: assert property (p_up) else $error("capture mode did not count up"); // R12

  property p_capture;
    (mode == crb_pkg::CRB_MODE_CAPTURE) && trig_ev && !cap_wr |=> cap_reload == $past(count);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong"); // R16

  property p_reload;
    (mode != crb_pkg::CRB_MODE_CAPTURE) && up_ovf && !cnt_wr && !trig_ev |=> count == $past(cap_reload);
  endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong"); // R17

  c_capture: cover property ((mode == crb_pkg::CRB_MODE_CAPTURE) && trig_ev);
  c_reload:  cover property ((mode == crb_pkg::CRB_MODE_RELOAD) && up_ovf);
  c_baud:    cover property (baud && ovf ##1 rx_clock_one);
  c_down:    cover property (dn_ovf);

endmodule
`default_nettype wire

// ---- shared/crb_pkg.sv ----
// Constants shared by the capture/reload/baud timer and its register slave.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
`default_nettype none
package crb_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFF_CONTROL    = 8'h00;
  localparam logic [7:0] OFF_MODE_EXT   = 8'h04;
  localparam logic [7:0] OFF_POWER_CTRL = 8'h08;
  localparam logic [7:0] OFF_COUNT      = 8'h0C;
  localparam logic [7:0] OFF_CAP_RELOAD = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h18;

  // ==========================================================================
  // Control register fields
  localparam int BIT_OVF      = 7;
  localparam int BIT_EXT      = 6;
  localparam int BIT_RX1      = 5;
  localparam int BIT_TX1      = 4;
  localparam int BIT_TRIG_EN  = 3;
  localparam int BIT_RUN      = 2;
  localparam int BIT_CNT_SEL  = 1;
  localparam int BIT_CPRL     = 0;
  // Mode extension, power control and interrupt fields.
  localparam int BIT_DIR_EN   = 0;
  localparam int BIT_RX2      = 1;
  localparam int BIT_TX2      = 0;
  localparam int IRQ_OVF      = 0;
  localparam int IRQ_EXT      = 1;

  // ==========================================================================
  // Reset values and limits
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;
  localparam int          MC_DIV        = 12;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    CRB_MODE_CAPTURE,
    CRB_MODE_RELOAD,
    CRB_MODE_BAUD
  } crb_mode_t;

endpackage
`default_nettype wire

// ---- logic/crb_fall_detect.sv ----
// Falling-edge detector for a group of synchronous pin inputs.
// Assumes the inputs are already synchronous to aclk.
`timescale 1ns/1ns
`default_nettype none
module crb_fall_detect #(
  parameter int WIDTH = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_prev;

  if (WIDTH < 1) begin : g_chk
    $error("crb_fall_detect needs WIDTH of at least 1");
  end

  always_comb begin
    next_prev = level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= '1;
    end else begin
      prev <= next_prev;
    end
  end

  // Each bit is a one-cycle pulse in the cycle the pin is first seen low.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign fall[i] = prev[i] & ~level[i];
  end

endmodule
`default_nettype wire

// ---- dv/crb_serial_partner.sv ----
// Far-side model: the other timer's overflow source and the serial ports' clock inputs.
// Assumes one aclk domain and one-cycle clock pulses from the timer.
`timescale 1ns/1ns
`default_nettype none
module crb_serial_partner (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic t1_en,
  input  wire logic rx_clock_one,
  input  wire logic tx_clock_one,
  input  wire logic rx_clock_two,
  input  wire logic tx_clock_two,
  output logic      timer1_overflow
);
  // Pulse counts: receive one, transmit one, receive two, transmit two.
  int cnt [4];
  int div;
  // ==========================================================================
  // Other timer and clock counters
  // The other timer is gated so that pass-through pulses can be told apart from this timer's own.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= 0;
      timer1_overflow <= 1'b0;
      cnt <= '{default: 0};
    end else begin
      div <= (div == 9) ? 0 : div + 1;
      timer1_overflow <= t1_en && (div == 9);
      cnt[0] <= cnt[0] + int'(rx_clock_one);
      cnt[1] <= cnt[1] + int'(tx_clock_one);
      cnt[2] <= cnt[2] + int'(rx_clock_two);
      cnt[3] <= cnt[3] + int'(tx_clock_two);
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_crb_timer.sv ----
// Self-checking bench for the capture/reload/baud timer.
// Assumes a short machine-cycle divider and the serial partner model on the clock outputs.
`timescale 1ns/1ns
`default_nettype none
module tb_crb_timer;
  localparam logic [7:0] A_CTL = crb_pkg::OFF_CONTROL;
  localparam logic [7:0] A_MX  = crb_pkg::OFF_MODE_EXT;
  localparam logic [7:0] A_PC  = crb_pkg::OFF_POWER_CTRL;
  localparam logic [7:0] A_CNT = crb_pkg::OFF_COUNT;
  localparam logic [7:0] A_CAP = crb_pkg::OFF_CAP_RELOAD;
  localparam logic [7:0] A_ST  = crb_pkg::OFF_IRQ_STATUS;
  localparam logic [7:0] A_MSK = crb_pkg::OFF_IRQ_MASK;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  aw_addr = '0, ar_addr = '0;
  logic [31:0] w_data = '0, rdata;
  logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, t1_ovf, rx1, tx1, rx2, tx2;
  logic [1:0]  bresp, rresp;
  logic        cnt_pin = 1'b1, trg_pin = 1'b1, t1_en = 1'b0;
  logic [3:0]  w_strb = 4'hF;
  int          fails = 0, checks = 0, m_count, m_cap, snap [4];

  always #25 aclk = ~aclk;

  crb_timer #(.MC_DIV(2)) crb_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_addr),
    .s_axi_awvalid(aw_valid), .s_axi_awready(awready), .s_axi_wdata(w_data), .s_axi_wstrb(w_strb),
    .s_axi_wvalid(w_valid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(b_ready), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(r_ready),
    .count_input_pin(cnt_pin), .trigger_input_pin(trg_pin), .timer1_overflow(t1_ovf),
    .rx_clock_one(rx1), .tx_clock_one(tx1), .rx_clock_two(rx2), .tx_clock_two(tx2), .irq(irq));

  crb_serial_partner crb_serial_partner_i (.aclk(aclk), .aresetn(aresetn), .t1_en(t1_en),
    .rx_clock_one(rx1), .tx_clock_one(tx1), .rx_clock_two(rx2), .tx_clock_two(tx2),
    .timer1_overflow(t1_ovf));

  // ==========================================================================
  // Bus, pin and comparison tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A wait that runs out leaves the response at 3 and counts as a mismatch.
  // The ready lines stay high between transfers so no line is driven twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    r = 2'h3;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (aw_valid && awready) aw_valid <= 1'b0;
      if (w_valid && wready) w_valid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    if (r == 2'h3) fails++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    d = '1;
    r = 2'h3;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (ar_valid && arready) ar_valid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    if (r == 2'h3) fails++;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, e);
  endtask

  // Which 0 pulses the count pin, 1 the trigger pin; each pulse gives one falling edge.
  task automatic fall(input int which, input int n);
    repeat (n) begin
      if (which == 0) cnt_pin <= 1'b0;
      else trg_pin <= 1'b0;
      repeat (2) @(posedge aclk);
      if (which == 0) cnt_pin <= 1'b1;
      else trg_pin <= 1'b1;
      repeat (2) @(posedge aclk);
    end
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    #(20000 * 50);
    fails++;
    conclude();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    void'($urandom(66876));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(A_CTL, 32'h0000_0000);
    rdc(A_CNT, 32'h0000_0000);
    wr(8'h1C, 32'h0000_00FF, r);
    check(32'(r), 32'(crb_pkg::RESP_SLVERR));
    rd(8'h1C, v, r);
    check(32'(r), 32'(crb_pkg::RESP_SLVERR));
    m_count = int'($urandom_range(16'hFFFF));
    wr(A_CNT, m_count, r);
    wr(A_CTL, 32'h0000_0009, r);
    fall(1, 1);
    rdc(A_CAP, m_count);
    rdc(A_CTL, 32'h0000_0049);
    check(32'(irq), 32'h0000_0000);
    wr(A_MSK, 32'h0000_0002, r);
    @(posedge aclk);
    check(32'(irq), 32'h0000_0001);
    wr(A_ST, 32'h0000_0002, r);
    @(posedge aclk);
    check(32'(irq), 32'h0000_0000);
    m_cap = int'($urandom_range(16'hFFF0));
    wr(A_CAP, m_cap, r);
    wr(A_CTL, 32'h0000_0008, r);
    fall(1, 1);
    rdc(A_CNT, m_cap);
    wr(A_CTL, 32'h0000_0000, r);
    wr(A_CNT, m_count, r);
    fall(1, 1);
    rdc(A_CNT, m_count);
    rdc(A_CTL, 32'h0000_0000);
    wr(A_CNT, 32'h0000_FFFF, r);
    wr(A_CTL, 32'h0000_0006, r);
    fall(0, 1);
    rdc(A_CNT, m_cap);
    rdc(A_CTL, 32'h0000_0086);
    fall(0, 3);
    rdc(A_CNT, m_cap + 3);
    wr(A_CTL, 32'h0000_0007, r);
    wr(A_CNT, 32'h0000_FFFF, r);
    fall(0, 2);
    rdc(A_CNT, 32'h0000_0001);
    rdc(A_CTL, 32'h0000_0087);
    wr(A_CTL, 32'h0000_0003, r);
    fall(0, 2);
    rdc(A_CNT, 32'h0000_0001);
    w_strb <= 4'h2;
    wr(A_CNT, 32'h0000_AB77, r);
    w_strb <= 4'hF;
    rdc(A_CNT, 32'h0000_AB01);
    wr(A_MX, 32'h0000_0001, r);
    wr(A_CTL, 32'h0000_0006, r);
    wr(A_CNT, 32'h0000_0010, r);
    wr(A_CAP, 32'h0000_0000, r);
    trg_pin <= 1'b0;
    fall(0, 3);
    rdc(A_CNT, 32'h0000_000D);
    trg_pin <= 1'b1;
    fall(0, 2);
    rdc(A_CNT, 32'h0000_000F);
    trg_pin <= 1'b0;
    wr(A_CNT, 32'h0000_0001, r);
    fall(0, 2);
    rdc(A_CNT, 32'h0000_FFFF);
    rdc(A_CTL, 32'h0000_0086);
    trg_pin <= 1'b1;
    wr(A_MX, 32'h0000_0000, r);
    wr(A_CTL, 32'h0000_0000, r);
    wr(A_CAP, 32'h0000_FFFE, r);
    wr(A_CNT, 32'h0000_FFFE, r);
    wr(A_PC, 32'h0000_0001, r);
    snap = crb_serial_partner_i.cnt;
    wr(A_CTL, 32'h0000_0024, r);
    repeat (60) @(posedge aclk);
    rdc(A_CTL, 32'h0000_0024);
    rd(A_CNT, v, r);
    check(32'(v[15:0] >= 16'hFFFE), 32'h0000_0001);
    check(32'(crb_serial_partner_i.cnt[0] > snap[0]), 32'h0000_0001);
    check(32'(crb_serial_partner_i.cnt[1] - snap[1]), 32'h0000_0000);
    check(32'(crb_serial_partner_i.cnt[3] > snap[3]), 32'h0000_0001);
    check(32'(crb_serial_partner_i.cnt[2] - snap[2]), 32'h0000_0000);
    wr(A_CTL, 32'h0000_0028, r);
    wr(A_CNT, m_count, r);
    fall(1, 1);
    rdc(A_CTL, 32'h0000_0068);
    rdc(A_CNT, m_count);
    wr(A_CTL, 32'h0000_0000, r);
    wr(A_PC, 32'h0000_0000, r);
    snap = crb_serial_partner_i.cnt;
    t1_en <= 1'b1;
    repeat (40) @(posedge aclk);
    check(32'(crb_serial_partner_i.cnt[1] > snap[1]), 32'h0000_0001);
    check(32'(crb_serial_partner_i.cnt[2] > snap[2]), 32'h0000_0001);
    check(32'(crb_serial_partner_i.cnt[0] > snap[0]), 32'h0000_0001);
    check(32'(crb_serial_partner_i.cnt[3] > snap[3]), 32'h0000_0001);
    conclude();
  end
endmodule
`default_nettype wire
